/* hdl/qdsl_top.sv */
module qdsl_top (
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_in,
  // Serial link, clocked by the host
  input  wire logic                    link_clk_in,
  input  wire logic                    serial_data_in,
  input  wire logic                    load_strobe_in,
  input  wire logic                    update_strobe_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [11:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // Channel latches
  output qdsl_pkg::qdsl_chan_s         channel_a_out,
  output qdsl_pkg::qdsl_chan_s         channel_b_out,
  output qdsl_pkg::qdsl_chan_s         channel_c_out,
  output qdsl_pkg::qdsl_chan_s         channel_d_out
);

  localparam int NCH = qdsl_pkg::NUM_CHAN;
  localparam int WB  = qdsl_pkg::WORD_BITS;
  localparam int CW  = qdsl_pkg::CNT_W;

  // ------------------------------------------------------------------
  // Link domain: serial input register
  // ------------------------------------------------------------------
  logic [WB-1:0] shift_q;
  logic [WB-1:0] shift_d;

  // Bits older than the last eleven fall off the top, so a 16-clock
  // transfer in two bursts leaves just the command word in place.
  assign shift_d = {shift_q[WB-2:0], serial_data_in};

  // No reset: the host clock may stand still, and the content only
  // matters once a full word has been shifted in.
  always_ff @(negedge link_clk_in) begin
    if (load_strobe_in) begin
      shift_q <= shift_d;
    end
  end

  // ------------------------------------------------------------------
  // Core domain: strobe synchronisers and edge detect
  // ------------------------------------------------------------------
  logic [1:0] strobe_sync;
  logic       load_s;
  logic       upd_s;
  logic       load_prev_q;
  logic       upd_prev_q;
  logic       load_fall;
  logic       upd_fall;

  qdsl_sync #(
    .WIDTH (2)
  ) u_strobe_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({update_strobe_in, load_strobe_in}),
    .sync_out    (strobe_sync)
  );

  assign load_s = strobe_sync[0];
  assign upd_s  = strobe_sync[1];

  // Previous values reset low, so a strobe held low through reset
  // gives no false edge; one must see the strobe high first.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      load_prev_q <= 1'h0;
      upd_prev_q  <= 1'h0;
    end else begin
      load_prev_q <= load_s;
      upd_prev_q  <= upd_s;
    end
  end

  assign load_fall = load_prev_q & ~load_s;
  assign upd_fall  = upd_prev_q & ~upd_s;

  // ------------------------------------------------------------------
  // Word capture and decode
  // ------------------------------------------------------------------
  // The shift register is read across domains only on load_fall. It
  // last moved before the strobe fell and cannot move while the
  // strobe is low, so all eleven bits are stable by then.
  logic             ctrl_accept_q;
  logic             accept;
  logic             ignore;
  logic [1:0]       sel;
  qdsl_pkg::qdsl_chan_s new_entry;
  logic [WB-1:0]    word_q;

  assign accept = load_fall & ctrl_accept_q;
  assign ignore = load_fall & ~ctrl_accept_q;

  assign sel = {shift_q[qdsl_pkg::SEL_HI_POS],
                shift_q[qdsl_pkg::SEL_LO_POS]};
  assign new_entry.range_double = shift_q[qdsl_pkg::RANGE_POS];
  assign new_entry.code = shift_q[qdsl_pkg::CODE_MSB:0];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      word_q <= '0;
    end else if (accept) begin
      word_q <= shift_q;
    end
  end

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic       apb_setup;
  logic       apb_access;
  logic       apb_wr;
  logic       aligned;
  logic       hit_ctrl;
  logic       hit_status;
  logic       hit_word;
  logic       hit_out;
  logic       hit_hold;
  logic       mapped;
  logic [1:0] rd_chan;
  logic       wr_ctrl;
  logic       sw_update;

  assign apb_setup  = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in;
  assign apb_wr     = apb_access & pwrite_in;
  assign aligned    = (paddr_in[1:0] == 2'h0);
  assign rd_chan    = paddr_in[3:2];

  assign hit_ctrl   = aligned & (paddr_in == qdsl_pkg::OFF_CTRL);
  assign hit_status = aligned & (paddr_in == qdsl_pkg::OFF_STATUS);
  assign hit_word   = aligned & (paddr_in == qdsl_pkg::OFF_WORD);
  assign hit_out    = aligned & (paddr_in[11:4] == qdsl_pkg::OFF_OUT[11:4]);
  assign hit_hold   = aligned &
                      (paddr_in[11:4] == qdsl_pkg::OFF_HOLD[11:4]);
  assign mapped     = hit_ctrl | hit_status | hit_word | hit_out |
                      hit_hold;

  assign wr_ctrl    = apb_wr & hit_ctrl;
  assign sw_update  = wr_ctrl & pwdata_in[qdsl_pkg::CTRL_SWUPD_POS];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_accept_q <= qdsl_pkg::CTRL_ACCEPT_RST;
    end else if (wr_ctrl) begin
      ctrl_accept_q <= pwdata_in[qdsl_pkg::CTRL_ACCEPT_POS];
    end
  end

  // ------------------------------------------------------------------
  // Channel hold and output latches
  // ------------------------------------------------------------------
  qdsl_pkg::qdsl_chan_s hold_q [NCH];
  qdsl_pkg::qdsl_chan_s out_q  [NCH];
  logic                 copy_all;
  logic                 direct;

  // A software update acts like a pulse on the update strobe
  assign copy_all = upd_fall | sw_update;
  assign direct   = accept & ~upd_s;

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    logic                 hit;
    qdsl_pkg::qdsl_chan_s hold_d;
    qdsl_pkg::qdsl_chan_s out_d;

    assign hit    = accept & (sel == 2'(i));
    assign hold_d = hit ? new_entry : hold_q[i];
    // A copy in the same cycle as a store takes the new word along
    assign out_d  = ((hit & direct) | copy_all) ? hold_d :
                                                  out_q[i];

    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        hold_q[i] <= qdsl_pkg::CHAN_RESET;
        out_q[i]  <= qdsl_pkg::CHAN_RESET;
      end else begin
        hold_q[i] <= hold_d;
        out_q[i]  <= out_d;
      end
    end
  end

  assign channel_a_out = out_q[0];
  assign channel_b_out = out_q[1];
  assign channel_c_out = out_q[2];
  assign channel_d_out = out_q[3];

  // ------------------------------------------------------------------
  // Status: pending flag and counters
  // ------------------------------------------------------------------
  logic          pend_q;
  logic          pend_set;
  logic [CW-1:0] wcnt_q;
  logic [CW-1:0] dcnt_q;

  assign pend_set = accept & upd_s;

  // Set wins over a copy in the same cycle, so pend_q stays set even
  // though the copy takes the word just held to its output as well.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pend_q <= 1'h0;
    end else if (pend_set) begin
      pend_q <= 1'h1;
    end else if (copy_all) begin
      pend_q <= 1'h0;
    end
  end

  // Counters wrap; software reads differences
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wcnt_q <= qdsl_pkg::CNT_RESET;
      dcnt_q <= qdsl_pkg::CNT_RESET;
    end else begin
      if (accept) begin
        wcnt_q <= wcnt_q + qdsl_pkg::CNT_ONE;
      end
      if (ignore) begin
        dcnt_q <= dcnt_q + qdsl_pkg::CNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------------
  logic [31:0] rd_ctrl;
  logic [31:0] rd_status;
  logic [31:0] rd_word;
  logic [31:0] rd_out;
  logic [31:0] rd_hold;
  logic [31:0] rd_data;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  assign rd_ctrl   = {31'h0, ctrl_accept_q};
  assign rd_status = {8'h00, dcnt_q, wcnt_q, 5'h00, upd_s, load_s, pend_q};
  assign rd_word   = {21'h0, word_q};
  assign rd_out    = {23'h0, out_q[rd_chan]};
  assign rd_hold   = {23'h0, hold_q[rd_chan]};

  assign rd_data = hit_ctrl   ? rd_ctrl   :
                   hit_status ? rd_status :
                   hit_word   ? rd_word   :
                   hit_out    ? rd_out    :
                   hit_hold   ? rd_hold   : 32'h0000_0000;

  // Read data is taken in the setup cycle, so the access cycle always
  // completes at once with a registered answer.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'h0;
    end else if (apb_setup) begin
      prdata_q  <= pwrite_in ? 32'h0000_0000 : rd_data;
      pslverr_q <= ~mapped;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = 1'h1;
  assign pslverr_out = pslverr_q & apb_access;

endmodule // qdsl_top

/* hdl/qdsl_pkg.sv */
// How it works
// - While the load strobe is high, each falling serial clock edge shifts the data pin into the input register.
// - With the update strobe low, the selected channel output changes at the falling edge of the load strobe.
// - With the update strobe high the word is held, and held words reach the outputs when the update strobe is pulsed low.
// - Words travel most significant bit first and are read in that order.
// - Select 00 picks channel A, 01 channel B, 10 channel C and 11 channel D.
// - The range bit is stored with the code: low gives one times the reference, high twice.
// - A word sent as two bursts of eight clocks is accepted, only the last eleven bits counting.
// - After reset every channel holds code zero.
package qdsl_pkg;

  localparam int WORD_BITS  = 11;
  localparam int CODE_BITS  = 8;
  localparam int NUM_CHAN   = 4;
  localparam int SEL_HI_POS = 10;
  localparam int SEL_LO_POS = 9;
  localparam int RANGE_POS  = 8;
  localparam int CODE_MSB   = 7;
  localparam int CNT_W      = 8;

  typedef struct packed {
    logic                 range_double;
    logic [CODE_BITS-1:0] code;
  } qdsl_chan_s;

  localparam qdsl_chan_s CHAN_RESET = 9'h000;

  localparam int         ADDR_W       = 12;
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_WORD    = 12'h008;
  localparam logic [11:0] OFF_OUT     = 12'h010;
  localparam logic [11:0] OFF_HOLD    = 12'h020;

  localparam int          CTRL_ACCEPT_POS = 0;
  localparam int          CTRL_SWUPD_POS  = 1;
  localparam logic        CTRL_ACCEPT_RST = 1'h1;

  localparam int          ST_PEND_POS     = 0;
  localparam int          ST_LOAD_POS     = 1;
  localparam int          ST_UPD_POS      = 2;
  localparam int          ST_WCNT_LSB     = 8;
  localparam int          ST_DCNT_LSB     = 16;
  localparam logic [CNT_W-1:0] CNT_RESET  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;

endpackage

/* hdl/qdsl_sync.sv */
module qdsl_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // qdsl_sync

/* tb/qdsl_checker.sv */
module qdsl_checker (
  input wire logic                 core_clk_in,
  input wire logic                 reset_in,
  input wire logic                 link_clk_in,
  input wire logic                 serial_data_in,
  input wire logic                 load_strobe_in,
  input wire logic                 update_strobe_in,
  input wire logic                 psel_in,
  input wire logic                 penable_in,
  input wire logic                 pwrite_in,
  input wire logic [11:0]          paddr_in,
  input wire logic [31:0]          pwdata_in,
  input wire logic [31:0]          prdata_out,
  input wire logic                 pready_out,
  input wire logic                 pslverr_out,
  input wire qdsl_pkg::qdsl_chan_s channel_a_out,
  input wire qdsl_pkg::qdsl_chan_s channel_b_out,
  input wire qdsl_pkg::qdsl_chan_s channel_c_out,
  input wire qdsl_pkg::qdsl_chan_s channel_d_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] shadow_q;
  logic [3:0]  cnt_q;
  logic        load_q;
  logic        upd_q;
  logic        keep_q;
  wire         acc;
  wire         mapped;
  wire         ctrl_wr;
  wire         sw_upd;
  wire         ev;
  wire  [35:0] outs;
  wire  [8:0]  sel_ch;
  assign acc     = psel_in & penable_in;
  assign mapped  = (paddr_in[1:0] == 2'h0) && ((paddr_in < 12'h00c) ||
                   ((paddr_in >= 12'h010) && (paddr_in < 12'h030)));
  assign ctrl_wr = acc & pwrite_in & (paddr_in == qdsl_pkg::OFF_CTRL);
  assign sw_upd  = ctrl_wr & pwdata_in[qdsl_pkg::CTRL_SWUPD_POS];
  assign ev      = (load_q & ~load_strobe_in) | (upd_q & ~update_strobe_in) |
                   sw_upd;
  assign outs    = {channel_a_out, channel_b_out, channel_c_out,
                    channel_d_out};
  assign sel_ch  = outs[9 * (3 - shadow_q[10:9]) +: 9];
  // Shadow of the serial word, so the decode can be predicted
  always_ff @(negedge link_clk_in) begin
    if (load_strobe_in) begin
      shadow_q <= {shadow_q[9:0], serial_data_in};
    end
  end
  // Cycles since the last strobe fall or software update, saturating;
  // keep_q follows the accept enable so dropped words are not expected
  always_ff @(posedge core_clk_in) begin
    load_q <= load_strobe_in;
    upd_q  <= update_strobe_in;
    if (reset_in) begin
      cnt_q  <= 4'hf;
      keep_q <= qdsl_pkg::CTRL_ACCEPT_RST;
    end else begin
      if (ev) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (ctrl_wr) begin
        keep_q <= pwdata_in[qdsl_pkg::CTRL_ACCEPT_POS];
      end
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence imm_s;
    $fell(load_strobe_in) && !update_strobe_in && keep_q;
  endsequence
  sequence held_s;
    $fell(load_strobe_in) && update_strobe_in;
  endsequence
  sequence drop_s;
    $fell(load_strobe_in) && !keep_q;
  endsequence
  rst_zero_a: assert property ($fell(reset_in) |-> outs == 36'h0)
    else $error("channel not zero after reset");
  imm_load_a: assert property (
    imm_s |-> ##[2:6] sel_ch == shadow_q[8:0])
    else $error("selected channel not loaded");
  held_load_a: assert property (
    held_s |-> ##1 $stable(sel_ch) [*6])
    else $error("held word reached output");
  drop_keep_a: assert property (drop_s |-> ##1 $stable(outs) [*6])
    else $error("dropped word reached output");
  out_cause_a: assert property (
    outs != $past(outs) |-> cnt_q <= 4'h6)
    else $error("output changed without a strobe");
  ready_high_a: assert property (pready_out)
    else $error("pready low");
  err_access_a: assert property (pslverr_out |-> acc)
    else $error("pslverr outside access");
  err_unmap_a: assert property (acc && !mapped |-> pslverr_out)
    else $error("unmapped access without pslverr");
  rd_zero_a: assert property (
    acc && !mapped && !pwrite_in |-> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  rd_out_a: assert property (acc && !pwrite_in &&
    paddr_in == qdsl_pkg::OFF_OUT |-> prdata_out == {23'h0, $past(outs[35:27])})
    else $error("output latch read wrong");
endmodule // qdsl_checker

bind qdsl_top qdsl_checker qdsl_checker_i (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
  .serial_data_in(serial_data_in), .load_strobe_in(load_strobe_in),
  .update_strobe_in(update_strobe_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .channel_a_out(channel_a_out),
  .channel_b_out(channel_b_out), .channel_c_out(channel_c_out),
  .channel_d_out(channel_d_out));

/* tb/qdsl_host_model.sv */
module qdsl_host_model (
  output logic link_clk_out,
  output logic serial_data_out,
  output logic load_strobe_out,
  output logic update_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_out = 1'b1;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b1;
    update_strobe_out = 1'b1;
  end
  // Clock stands high between bursts; data moves on the rising edge
  task automatic shift(input logic [10:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_out = w[i];
      #62.5 link_clk_out = 1'b0;
      #62.5 link_clk_out = 1'b1;
    end
    serial_data_out = ~serial_data_out;
  endtask
  // Strobes move by non-blocking assignment, as a call may start on a
  // core clock edge and the core samples them there
  task automatic load_word;
    #60 load_strobe_out <= 1'b0;
    #250 load_strobe_out <= 1'b1;
    #60;
  endtask
  task automatic set_update(input logic v);
    update_strobe_out <= v;
    #60;
  endtask
  task automatic pulse_update;
    update_strobe_out <= 1'b0;
    #250 update_strobe_out <= 1'b1;
    #60;
  endtask
endmodule // qdsl_host_model

/* tb/tb_quad_dac_serial_load.sv */
module tb_quad_dac_serial_load;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk_in, reset_in, psel_in, penable_in, pwrite_in;
  logic [11:0]          paddr_in;
  logic [31:0]          pwdata_in, prdata_out, rd;
  logic                 pready_out, pslverr_out, er;
  wire                  lclk, sdat, load, upd;
  qdsl_pkg::qdsl_chan_s ch_out [4];
  logic [8:0]           exp_q [4];
  int                   err_count, n_tests;

  qdsl_top qdsl_top_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .link_clk_in(lclk), .serial_data_in(sdat), .load_strobe_in(load),
    .update_strobe_in(upd), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .channel_a_out(ch_out[0]),
    .channel_b_out(ch_out[1]), .channel_c_out(ch_out[2]),
    .channel_d_out(ch_out[3]));
  qdsl_host_model qdsl_host_model_i (.link_clk_out(lclk),
    .serial_data_out(sdat), .load_strobe_out(load), .update_strobe_out(upd));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Sends one word per channel and checks outputs against the model copy
  task automatic load_all(input logic r, input logic [7:0] base,
                          input logic now);
    for (int c = 0; c < 4; c++) begin
      qdsl_host_model_i.shift({c[1:0], r ^ c[0], base + c[7:0] * 8'h11}, 11);
      qdsl_host_model_i.load_word();
      repeat (2) @(posedge core_clk_in);
      if (now) exp_q[c] = {r ^ c[0], base + c[7:0] * 8'h11};
      chk("chan", 32'(exp_q[c]), 32'(ch_out[c]));
    end
  endtask

  task automatic t_reset;
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, qdsl_pkg::OFF_OUT + 12'(4 * c), 32'h0);
      chk("reset latch", 32'h0, rd);
    end
    apb(1'b0, qdsl_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    $display("reset test done");
  endtask

  task automatic t_held;
    qdsl_host_model_i.set_update(1'b1);
    load_all(1'b1, 8'h7e, 1'b0);
    qdsl_host_model_i.pulse_update();
    repeat (2) @(posedge core_clk_in);
    for (int c = 0; c < 4; c++) begin
      exp_q[c] = {~c[0], 8'h7e + c[7:0] * 8'h11};
      chk("held copy", {23'h0, exp_q[c]}, {23'h0, ch_out[c]});
    end
    $display("held update test done");
  endtask

  task automatic t_burst;
    qdsl_host_model_i.set_update(1'b0);
    qdsl_host_model_i.shift({3'h0, 5'h15, 3'h6}, 8);
    qdsl_host_model_i.shift(11'h0c3, 8);
    qdsl_host_model_i.load_word();
    repeat (2) @(posedge core_clk_in);
    exp_q[3] = 9'h0c3;
    chk("burst word", 32'h0c3, {23'h0, ch_out[3]});
    $display("two burst test done");
  endtask

  task automatic t_apb;
    apb(1'b0, qdsl_pkg::OFF_WORD, 32'h0);
    chk("last word", 32'h6c3, rd);
    apb(1'b0, qdsl_pkg::OFF_OUT + 12'h004, 32'h0);
    chk("latch read", {23'h0, exp_q[1]}, rd);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h002, 32'h0);
    chk("unaligned err", 32'h1, {31'h0, er});
    apb(1'b1, qdsl_pkg::OFF_CTRL, 32'h3);
    chk("ctrl err", 32'h0, {31'h0, er});
    $display("register test done");
  endtask

  // With the accept enable cleared a word must change nothing but the
  // dropped count; nine words were accepted before this point
  task automatic t_drop;
    apb(1'b1, qdsl_pkg::OFF_CTRL, 32'h0);
    qdsl_host_model_i.shift(11'h0a5, 11);
    qdsl_host_model_i.load_word();
    repeat (2) @(posedge core_clk_in);
    chk("dropped word", {23'h0, exp_q[0]}, {23'h0, ch_out[0]});
    apb(1'b0, qdsl_pkg::OFF_STATUS, 32'h0);
    chk("status counts", 32'h0001_0902, rd);
    apb(1'b1, qdsl_pkg::OFF_CTRL, 32'h1);
    $display("drop test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    reset_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    err_count = 0;
    n_tests = 0;
    exp_q = '{default: 9'h000};
    repeat (3) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset();
    qdsl_host_model_i.set_update(1'b0);
    load_all(1'b0, 8'h81, 1'b1);
    $display("immediate load test done");
    t_held();
    t_burst();
    t_apb();
    t_drop();
    print_verdict();
  end
endmodule // tb_quad_dac_serial_load
